//--- design/timer16.sv
// Behaviour
// - Counter, compares, capture are 16 bits; control registers 8 bits.
// - Every request shows as a flag and has its own mask bit.
// - Tick from prescaler or external pin edge; clock select CS_OFF stops counter.
// - Buffered compares checked continuously; matches drive output pins.
// - Each compare match sets that channel's match flag.
// - Capture edge from pin or comparator copies counter to capture unless capture is the peak.
// - Capture path has a noise-cancelling filter.
// - Peak is 0xFFFF, 0x00FF, 0x01FF, 0x03FF, compare A or capture by mode.
// - Compare A as PWM peak gives no PWM output on pin A; it stays buffered.
// - Zero floor at 0x0000, full scale at 0xFFFF.
// - One shared 8-bit high-byte holding register.
// - Low-byte write loads held high byte and low byte together.
// - Low-byte read copies the high byte into the holding register.
// - Compare reads bypass the holding register and leave it alone.
// - Counter high-byte address reaches the holding register.
// - A counter write beats a same-cycle clear or count.
`timescale 1ns/100ps
`default_nettype none
module timer16
  import timer16_pkg::*;
(
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       sys_rst,
  // Register port
  input  wire logic [3:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr_en,
  input  wire logic       rd_en,
  output var  logic [7:0] rdata,
  // Pins
  input  wire logic       ext_count_pin,
  input  wire logic       capture_input_pin,
  input  wire logic       comparator_out,
  input  wire logic       capture_from_comparator,
  output var  logic       compare_output_pin_a,
  output var  logic       compare_output_pin_b,
  // Interrupt
  output var  logic       irq
);
  import timer16_pkg::*;

  logic [7:0]  ctrl_a_reg;
  logic [7:0]  ctrl_b_reg;
  logic [15:0] counter_value_reg;
  logic [15:0] cmp_a_reg;
  logic [15:0] cmp_b_reg;
  logic [15:0] cmp_a_buf_reg;
  logic [15:0] cmp_b_buf_reg;
  logic [15:0] capture_value_reg;
  logic [7:0]  hold_reg;
  logic [3:0]  flag_reg;
  logic [3:0]  mask_reg;
  logic        power_off_reg;
  logic [9:0]  presc_reg;
  logic [1:0]  ext_sync_reg;
  logic        ext_prev_reg;
  logic [1:0]  cap_sync_reg;
  logic [FILT_LEN-1:0] filt_reg;
  logic        cap_level_reg;
  logic        cap_prev_reg;

  logic [3:0]  mode;
  logic [2:0]  clk_sel;
  logic        tick;
  logic        running;
  logic        is_pwm;
  logic        cap_is_peak;
  logic [15:0] peak;
  logic        at_peak;
  logic        at_zero;
  logic        at_full;
  logic        match_a;
  logic        match_b;
  logic        cap_raw;
  logic        cap_edge;
  logic        cnt_wr;
  logic [3:0]  flag_set;
  logic        flag_rd;

  function automatic logic is_addr(input logic [3:0] a, input logic [3:0] t);
    is_addr = (a == t);
  endfunction

  assign mode    = {ctrl_b_reg[CB_MODE_HI +: 2], ctrl_a_reg[CA_MODE_LO +: 2]};
  assign clk_sel = ctrl_b_reg[CB_CS_LO +: 3];
  // Power-off holds every tick source, capture and compare event low
  assign running = !power_off_reg;
  assign is_pwm  = (mode == MODE_PWM8) || (mode == MODE_PWM9) ||
                   (mode == MODE_PWM10) || (mode == MODE_PWM_CAP) ||
                   (mode == MODE_PWM_A);
  assign cap_is_peak = (mode == MODE_CTC_CAP) || (mode == MODE_PWM_CAP);

  // Clock select
  always_comb
  begin
    unique case (clk_sel)
      CS_OFF:      tick = 1'b0;
      CS_DIV1:     tick = 1'b1;
      CS_DIV8:     tick = (presc_reg[2:0] == 3'h7);
      CS_DIV64:    tick = (presc_reg[5:0] == 6'h3F);
      CS_DIV256:   tick = (presc_reg[7:0] == 8'hFF);
      CS_DIV1K:    tick = (presc_reg == 10'h3FF);
      CS_EXT_FALL: tick = ext_prev_reg && !ext_sync_reg[1];
      CS_EXT_RISE: tick = !ext_prev_reg && ext_sync_reg[1];
    endcase
    tick = tick && running;
  end

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      presc_reg <= RST_PRESC;
    else if (running)
      presc_reg <= presc_reg + 10'h001;
  end

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ext_sync_reg <= 2'h0;
      ext_prev_reg <= 1'b0;
    end
    else
    begin
      ext_sync_reg <= {ext_sync_reg[0], ext_count_pin};
      ext_prev_reg <= ext_sync_reg[1];
    end
  end

  // Peak selection
  always_comb
  begin
    unique case (mode)
      MODE_PWM8:    peak = PEAK_8;
      MODE_PWM9:    peak = PEAK_9;
      MODE_PWM10:   peak = PEAK_10;
      MODE_CTC_A,
      MODE_PWM_A:   peak = cmp_a_reg;
      MODE_CTC_CAP,
      MODE_PWM_CAP: peak = capture_value_reg;
      default:      peak = FULL_SCALE;
    endcase
  end

  assign at_zero = (counter_value_reg == ZERO_FLOOR);
  assign at_full = (counter_value_reg == FULL_SCALE);
  assign at_peak = (counter_value_reg == peak);
  assign match_a = (counter_value_reg == cmp_a_reg);
  assign match_b = (counter_value_reg == cmp_b_reg);
  assign cnt_wr  = wr_en && is_addr(addr, ADDR_CNT_LO);

  // Counter: up-count, wraps at peak; software write wins
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      counter_value_reg <= RST_WORD;
    else if (cnt_wr)
      counter_value_reg <= {hold_reg, wdata};
    else if (tick)
      counter_value_reg <= at_peak ? ZERO_FLOOR
                                   : counter_value_reg + 16'h0001;
  end

  // Compare buffers: PWM modes load at the peak so a period never glitches
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cmp_a_buf_reg <= RST_WORD;
      cmp_b_buf_reg <= RST_WORD;
      cmp_a_reg     <= RST_WORD;
      cmp_b_reg     <= RST_WORD;
    end
    else
    begin
      if (wr_en && is_addr(addr, ADDR_CMPA_LO))
        cmp_a_buf_reg <= {hold_reg, wdata};
      if (wr_en && is_addr(addr, ADDR_CMPB_LO))
        cmp_b_buf_reg <= {hold_reg, wdata};
      if (!is_pwm || (tick && at_peak))
      begin
        cmp_a_reg <= cmp_a_buf_reg;
        cmp_b_reg <= cmp_b_buf_reg;
      end
    end
  end

  // Compare output pins
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      compare_output_pin_a <= 1'b0;
      compare_output_pin_b <= 1'b0;
    end
    else if (tick)
    begin
      if (!ctrl_a_reg[CA_OUTA_EN] || mode == MODE_PWM_A)
        compare_output_pin_a <= 1'b0;
      else if (is_pwm)
        compare_output_pin_a <= at_peak ? 1'b1 : (match_a ? 1'b0
                                : compare_output_pin_a);
      else if (match_a)
        compare_output_pin_a <= !compare_output_pin_a;
      if (!ctrl_a_reg[CA_OUTB_EN])
        compare_output_pin_b <= 1'b0;
      else if (is_pwm)
        compare_output_pin_b <= at_peak ? 1'b1 : (match_b ? 1'b0
                                : compare_output_pin_b);
      else if (match_b)
        compare_output_pin_b <= !compare_output_pin_b;
    end
  end

  // Capture input: sync, optional 5-sample filter, edge detect
  assign cap_raw = capture_from_comparator ? comparator_out
                                           : cap_sync_reg[1];

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cap_sync_reg  <= 2'h0;
      filt_reg      <= RST_FILT;
      cap_level_reg <= 1'b0;
      cap_prev_reg  <= 1'b0;
    end
    else
    begin
      cap_sync_reg <= {cap_sync_reg[0], capture_input_pin};
      filt_reg     <= {filt_reg[FILT_LEN-2:0], cap_raw};
      // Filter costs FILT_LEN cycles of latency but rejects short spikes
      if (!ctrl_b_reg[CB_FILT_EN])
        cap_level_reg <= cap_raw;
      else if (&{filt_reg, cap_raw})
        cap_level_reg <= 1'b1;
      else if (!(|{filt_reg, cap_raw}))
        cap_level_reg <= 1'b0;
      cap_prev_reg <= cap_level_reg;
    end
  end

  assign cap_edge = running && (ctrl_b_reg[CB_CAP_EDGE]
                    ? (cap_level_reg && !cap_prev_reg)
                    : (!cap_level_reg && cap_prev_reg));

  // Capture register: write allowed only while it sets the peak
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      capture_value_reg <= RST_WORD;
    else if (cap_is_peak)
    begin
      if (wr_en && is_addr(addr, ADDR_CAP_LO))
        capture_value_reg <= {hold_reg, wdata};
    end
    else if (cap_edge)
      capture_value_reg <= counter_value_reg;
  end

  // Holding register shared by all 16-bit registers
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      hold_reg <= RST_BYTE;
    else if (wr_en && (is_addr(addr, ADDR_CNT_HI) ||
             is_addr(addr, ADDR_CMPA_HI) || is_addr(addr, ADDR_CMPB_HI) ||
             is_addr(addr, ADDR_CAP_HI)))
      hold_reg <= wdata;
    else if (rd_en && is_addr(addr, ADDR_CNT_LO))
      hold_reg <= counter_value_reg[15:8];
    else if (rd_en && is_addr(addr, ADDR_CAP_LO))
      hold_reg <= capture_value_reg[15:8];
  end

  // Flags: set wins over clear-on-read
  assign flag_set[FL_OVF]  = tick && (is_pwm ? at_zero : at_peak && at_full);
  assign flag_set[FL_CMPA] = tick && match_a;
  assign flag_set[FL_CMPB] = tick && match_b;
  assign flag_set[FL_CAP]  = cap_edge && !cap_is_peak;
  assign flag_rd = rd_en && is_addr(addr, ADDR_FLAGS);

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      flag_reg <= 4'h0;
    else
      flag_reg <= (flag_rd ? 4'h0 : flag_reg) | flag_set;
  end

  assign irq = |(flag_reg & mask_reg);

  // Plain control (8-bit), mask (4-bit) and power (1-bit) registers, no ordering restrictions
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ctrl_a_reg    <= RST_BYTE;
      ctrl_b_reg    <= RST_BYTE;
      mask_reg      <= 4'h0;
      power_off_reg <= RST_POWER;
    end
    else if (wr_en)
    begin
      if (is_addr(addr, ADDR_CTRL_A))
        ctrl_a_reg <= wdata;
      if (is_addr(addr, ADDR_CTRL_B))
        ctrl_b_reg <= wdata;
      if (is_addr(addr, ADDR_MASK))
        mask_reg <= wdata[3:0];
      if (is_addr(addr, ADDR_POWER))
        power_off_reg <= wdata[0];
    end
  end

  // Read data, one cycle after the strobe
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      rdata <= RST_BYTE;
    else if (rd_en)
    begin
      unique case (addr)
        ADDR_CTRL_A:  rdata <= ctrl_a_reg;
        ADDR_CTRL_B:  rdata <= ctrl_b_reg;
        ADDR_CNT_LO:  rdata <= counter_value_reg[7:0];
        ADDR_CNT_HI:  rdata <= hold_reg;
        ADDR_CMPA_LO: rdata <= cmp_a_buf_reg[7:0];
        ADDR_CMPA_HI: rdata <= cmp_a_buf_reg[15:8];
        ADDR_CMPB_LO: rdata <= cmp_b_buf_reg[7:0];
        ADDR_CMPB_HI: rdata <= cmp_b_buf_reg[15:8];
        ADDR_CAP_LO:  rdata <= capture_value_reg[7:0];
        ADDR_CAP_HI:  rdata <= hold_reg;
        ADDR_FLAGS:   rdata <= {4'h0, flag_reg};
        ADDR_MASK:    rdata <= {4'h0, mask_reg};
        ADDR_POWER:   rdata <= {7'h00, power_off_reg};
        default:      rdata <= RST_BYTE;
      endcase
    end
  end

endmodule
`default_nettype wire

//--- inc/timer16_pkg.sv
package timer16_pkg;

  // Byte register map (8-bit data bus, byte addresses)
  localparam logic [3:0] ADDR_CTRL_A   = 4'h0;
  localparam logic [3:0] ADDR_CTRL_B   = 4'h1;
  localparam logic [3:0] ADDR_CNT_LO   = 4'h2;
  localparam logic [3:0] ADDR_CNT_HI   = 4'h3;
  localparam logic [3:0] ADDR_CMPA_LO  = 4'h4;
  localparam logic [3:0] ADDR_CMPA_HI  = 4'h5;
  localparam logic [3:0] ADDR_CMPB_LO  = 4'h6;
  localparam logic [3:0] ADDR_CMPB_HI  = 4'h7;
  localparam logic [3:0] ADDR_CAP_LO   = 4'h8;
  localparam logic [3:0] ADDR_CAP_HI   = 4'h9;
  localparam logic [3:0] ADDR_FLAGS    = 4'hA;
  localparam logic [3:0] ADDR_MASK     = 4'hB;
  localparam logic [3:0] ADDR_POWER    = 4'hC;

  // Control A: [1:0] mode low bits, [2] compare A pin enable,
  // [3] compare B pin enable
  localparam int CA_MODE_LO = 0;
  localparam int CA_OUTA_EN = 2;
  localparam int CA_OUTB_EN = 3;
  // Control B: [2:0] clock select, [4:3] mode high bits,
  // [6] capture edge (1 = rising), [7] noise filter enable
  localparam int CB_CS_LO   = 0;
  localparam int CB_MODE_HI = 3;
  localparam int CB_CAP_EDGE = 6;
  localparam int CB_FILT_EN = 7;

  // Flag / mask layout
  localparam int FL_OVF  = 0;
  localparam int FL_CMPA = 1;
  localparam int FL_CMPB = 2;
  localparam int FL_CAP  = 3;

  // Clock select codes
  localparam logic [2:0] CS_OFF    = 3'h0;
  localparam logic [2:0] CS_DIV1   = 3'h1;
  localparam logic [2:0] CS_DIV8   = 3'h2;
  localparam logic [2:0] CS_DIV64  = 3'h3;
  localparam logic [2:0] CS_DIV256 = 3'h4;
  localparam logic [2:0] CS_DIV1K  = 3'h5;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;

  // Peak source modes (four-bit mode field)
  localparam logic [3:0] MODE_NORMAL  = 4'h0;
  localparam logic [3:0] MODE_PWM8    = 4'h1;
  localparam logic [3:0] MODE_PWM9    = 4'h2;
  localparam logic [3:0] MODE_PWM10   = 4'h3;
  localparam logic [3:0] MODE_CTC_A   = 4'h4;
  localparam logic [3:0] MODE_CTC_CAP = 4'h5;
  localparam logic [3:0] MODE_PWM_CAP = 4'h6;
  localparam logic [3:0] MODE_PWM_A   = 4'h7;

  // Count values
  localparam logic [15:0] ZERO_FLOOR = 16'h0000;
  localparam logic [15:0] FULL_SCALE = 16'hFFFF;
  localparam logic [15:0] PEAK_8     = 16'h00FF;
  localparam logic [15:0] PEAK_9     = 16'h01FF;
  localparam logic [15:0] PEAK_10    = 16'h03FF;

  // Reset values
  localparam logic [7:0]  RST_BYTE   = 8'h00;
  localparam logic [15:0] RST_WORD   = 16'h0000;
  localparam logic        RST_POWER  = 1'b1;
  localparam logic [9:0]  RST_PRESC  = 10'h000;
  localparam logic [3:0]  RST_FILT   = 4'h0;
  localparam int          FILT_LEN   = 4;

endpackage

//--- sim/cpu_model.sv
`timescale 1ns/100ps
`default_nettype none
module cpu_model
  import timer16_pkg::*;
(
  // Clock
  input  wire logic       ref_clk,
  // Register port
  output var  logic [3:0] addr,
  output var  logic [7:0] wdata,
  output var  logic       wr_en,
  output var  logic       rd_en,
  input  wire logic [7:0] rdata
);
  initial
  begin
    addr  = 4'h0;
    wdata = 8'h00;
    wr_en = 1'b0;
    rd_en = 1'b0;
  end

  // Leaves the strobe up so a second write may follow with no gap
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    addr  <= a;
    wdata <= d;
    wr_en <= 1'b1;
    rd_en <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic rest();
    wr_en <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic wr1(input logic [3:0] a, input logic [7:0] d);
    wr(a, d);
    rest();
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    addr  <= a;
    wr_en <= 1'b0;
    rd_en <= 1'b1;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    @(posedge ref_clk);
    d = rdata;
  endtask

  // Pairs are never split by another access
  task automatic wr16(input logic [3:0] a, input logic [15:0] v);
    wr(a + 4'h1, v[15:8]);
    wr(a, v[7:0]);
    rest();
  endtask

  task automatic rd16(input logic [3:0] a, output logic [15:0] v);
    rd(a, v[7:0]);
    rd(a + 4'h1, v[15:8]);
  endtask

  task automatic power_up();
    wr1(ADDR_POWER, 8'h00);
  endtask
endmodule
`default_nettype wire

//--- sim/timer16_chk.sv
`timescale 1ns/100ps
`default_nettype none
module timer16_chk
  import timer16_pkg::*;
(
  // Clock, reset and register port
  input wire logic       ref_clk,
  input wire logic       sys_rst,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr_en,
  input wire logic       rd_en,
  input wire logic [7:0] rdata,
  // Outputs
  input wire logic       compare_output_pin_a,
  input wire logic       irq
);
  logic [7:0] tmp_reg;
  logic       tmp_ok_reg;
  logic [7:0] ca_reg;
  logic [7:0] cb_reg;
  logic [7:0] mask_reg;
  logic       off_reg;
  logic       idle;
  logic       hi_wr;
  logic [3:0] mode;
  assign idle  = off_reg || cb_reg[2:0] == CS_OFF;
  assign hi_wr = wr_en && addr[0] && addr > ADDR_CNT_LO && addr < ADDR_FLAGS;
  assign mode  = {cb_reg[4:3], ca_reg[1:0]};

  // Holding byte is only known until a low read refills it
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      tmp_ok_reg <= 1'b0;
    else if (hi_wr)
      tmp_ok_reg <= 1'b1;
    else if (rd_en && addr inside {ADDR_CNT_LO, ADDR_CAP_LO})
      tmp_ok_reg <= 1'b0;
  end

  always_ff @(posedge ref_clk)
  begin
    if (hi_wr)
      tmp_reg <= wdata;
  end

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ca_reg   <= RST_BYTE;
      cb_reg   <= RST_BYTE;
      mask_reg <= RST_BYTE;
      off_reg  <= RST_POWER;
    end
    else if (wr_en)
      case (addr)
        ADDR_CTRL_A: ca_reg   <= wdata;
        ADDR_CTRL_B: cb_reg   <= wdata;
        ADDR_MASK:   mask_reg <= wdata;
        ADDR_POWER:  off_reg  <= wdata[0];
        default:     ;
      endcase
  end

  default clocking dc @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);

  AST_UNMAPPED_ZERO: assert property (
    rd_en && addr > ADDR_POWER |=> rdata == 8'h00) else $error("bad rdata");
  AST_RDATA_STANDS: assert property (
    !rd_en |=> $stable(rdata)) else $error("rdata moved");
  AST_CNT_HI_HOLD: assert property (
    rd_en && addr == ADDR_CNT_HI && tmp_ok_reg |=> rdata == tmp_reg)
    else $error("counter high not from holding byte");
  AST_CAP_HI_HOLD: assert property (
    rd_en && addr == ADDR_CAP_HI && tmp_ok_reg |=> rdata == tmp_reg)
    else $error("capture high not from holding byte");
  AST_LOW_COMMIT: assert property (
    idle && hi_wr && addr == ADDR_CNT_HI ##1 idle && wr_en
    && addr == ADDR_CNT_LO ##1 idle && rd_en && addr == ADDR_CNT_LO
    |=> rdata == $past(wdata, 2)) else $error("low write not committed");
  AST_MASK_GATES: assert property (
    mask_reg[3:0] == 4'h0 |-> !irq) else $error("irq while all masked");
  AST_IRQ_DROP: assert property (
    $fell(irq) |-> $past(rd_en && addr == ADDR_FLAGS
    || wr_en && addr == ADDR_MASK)) else $error("irq dropped");
  AST_PWM_A_QUIET: assert property (
    (mode == MODE_PWM_A) [*3] |-> !compare_output_pin_a)
    else $error("pin A driven in peak mode");

  COV_HI_READ: cover property (rd_en && addr == ADDR_CNT_HI && tmp_ok_reg);
  COV_IRQ_DROP: cover property ($fell(irq));
  COV_PWM_A: cover property (mode == MODE_PWM_A);
endmodule

bind timer16 timer16_chk timer16_chk_i (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .addr(addr), .wdata(wdata),
  .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .irq(irq),
  .compare_output_pin_a(compare_output_pin_a)
);
`default_nettype wire

//--- sim/timer16_tb.sv
`timescale 1ns/100ps
`default_nettype none
module timer16_tb;
  import timer16_pkg::*;
  logic        ref_clk, sys_rst, wr_en, rd_en, irq;
  logic        ext_pin, cap_pin, cmp_out, cap_sel, pin_a, pin_b;
  logic [3:0]  addr;
  logic [7:0]  wdata, rdata, b;
  logic [15:0] v;
  int          errors, checks_done;

  timer16 timer16_i (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .ext_count_pin(ext_pin),
    .capture_input_pin(cap_pin), .comparator_out(cmp_out),
    .capture_from_comparator(cap_sel), .compare_output_pin_a(pin_a),
    .compare_output_pin_b(pin_b), .irq(irq)
  );
  cpu_model cpu_model_i (
    .ref_clk(ref_clk), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata(rdata)
  );

  always #12.5 ref_clk = ~ref_clk;

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic results();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic run(input int n);
    cpu_model_i.wr1(ADDR_CTRL_B, {5'h00, CS_DIV1});
    repeat (n) @(posedge ref_clk);
    cpu_model_i.wr1(ADDR_CTRL_B, 8'h00);
  endtask

  task automatic pulse(input logic cmp, input int w);
    @(posedge ref_clk) {cmp_out, cap_pin} <= {cmp, !cmp};
    repeat (w) @(posedge ref_clk);
    {cmp_out, cap_pin} <= 2'b00;
    repeat (12) @(posedge ref_clk);
  endtask

  task automatic t_access();
    cpu_model_i.wr(ADDR_CNT_HI, 8'h12);
    cpu_model_i.wr(ADDR_CNT_LO, 8'h34);
    cpu_model_i.rd(ADDR_CNT_LO, b);
    chk(b, 8'h34);
    cpu_model_i.rd(ADDR_CNT_HI, b);
    chk(b, 8'h12);
    cpu_model_i.wr1(ADDR_CMPA_HI, 8'h77);
    cpu_model_i.rd(ADDR_CNT_HI, b);
    chk(b, 8'h77);
    cpu_model_i.wr1(ADDR_CAP_HI, 8'h3C);
    cpu_model_i.rd(ADDR_CAP_HI, b);
    chk(b, 8'h3C);
    cpu_model_i.wr16(ADDR_CMPA_LO, 16'hABCD);
    cpu_model_i.rd(ADDR_CNT_LO, b);
    cpu_model_i.rd(ADDR_CMPA_HI, b);
    chk(b, 8'hAB);
    cpu_model_i.rd(ADDR_CNT_HI, b);
    chk(b, 8'h12);
    cpu_model_i.rd16(ADDR_CNT_LO, v);
    chk(v, 16'h1234);
    cpu_model_i.wr1(ADDR_CTRL_B, {5'h00, CS_DIV1});
    cpu_model_i.wr16(ADDR_CNT_LO, 16'h0100);
    cpu_model_i.wr1(ADDR_CTRL_B, 8'h00);
    cpu_model_i.rd16(ADDR_CNT_LO, v);
    chk(v, 16'h0102);
    $display("test access done");
  endtask

  task automatic t_irq();
    cpu_model_i.wr16(ADDR_CNT_LO, 16'h0000);
    cpu_model_i.wr16(ADDR_CMPA_LO, 16'h0010);
    cpu_model_i.wr16(ADDR_CMPB_LO, 16'h0020);
    cpu_model_i.rd(ADDR_FLAGS, b);
    run(60);
    chk(irq, 1'b0);
    cpu_model_i.wr1(ADDR_MASK, 8'h01 << FL_CMPB);
    chk(irq, 1'b1);
    cpu_model_i.rd(ADDR_FLAGS, b);
    chk(b, 8'h06);
    chk(irq, 1'b0);
    cpu_model_i.wr1(ADDR_MASK, 8'h00);
    $display("test irq done");
  endtask

  task automatic t_peak();
    logic [15:0] top;
    for (int m = 0; m < 4; m++)
    begin
      top = m == 0 ? FULL_SCALE : m == 1 ? PEAK_8 : m == 2 ? PEAK_9 : PEAK_10;
      cpu_model_i.wr1(ADDR_CTRL_A, 8'(m));
      cpu_model_i.wr16(ADDR_CNT_LO, top - 16'h000F);
      cpu_model_i.rd(ADDR_FLAGS, b);
      run(40);
      cpu_model_i.rd16(ADDR_CNT_LO, v);
      chk(v < 16'h0028, 1'b1);
      cpu_model_i.rd(ADDR_FLAGS, b);
      chk(b[FL_OVF], 1'b1);
    end
    $display("test peak done");
  endtask

  task automatic t_pwm_a();
    logic seen_b;
    seen_b = 1'b0;
    cpu_model_i.wr1(ADDR_CTRL_A, 8'h00);
    cpu_model_i.wr16(ADDR_CNT_LO, 16'h0000);
    cpu_model_i.wr16(ADDR_CMPA_LO, 16'h0020);
    cpu_model_i.wr16(ADDR_CMPB_LO, 16'h0010);
    cpu_model_i.wr1(ADDR_CTRL_A, 8'h0F);
    cpu_model_i.wr1(ADDR_CTRL_B, {3'h0, 2'h1, CS_DIV1});
    repeat (100)
    begin
      @(negedge ref_clk);
      chk(pin_a, 1'b0);
      seen_b = seen_b | pin_b;
    end
    chk(seen_b, 1'b1);
    cpu_model_i.wr1(ADDR_CTRL_B, 8'h00);
    cpu_model_i.wr1(ADDR_CTRL_A, 8'h00);
    $display("test pwm done");
  endtask

  task automatic t_capture();
    for (int s = 0; s < 2; s++)
    begin
      cpu_model_i.wr16(ADDR_CNT_LO, 16'h4321 + 16'(s));
      cpu_model_i.wr1(ADDR_CTRL_B, 8'h40);
      cap_sel <= s[0];
      pulse(s[0], 10);
      cpu_model_i.rd16(ADDR_CAP_LO, v);
      chk(v, 16'h4321 + 16'(s));
    end
    cap_sel <= 1'b0;
    cpu_model_i.wr1(ADDR_CTRL_B, 8'hC0);
    for (int w = 2; w < 12; w += 9)
    begin
      cpu_model_i.rd(ADDR_FLAGS, b);
      pulse(1'b0, w);
      cpu_model_i.rd(ADDR_FLAGS, b);
      chk(b[FL_CAP], w > 2);
    end
    $display("test capture done");
  endtask

  task automatic t_ext();
    for (int e = 0; e < 2; e++)
    begin
      cpu_model_i.wr16(ADDR_CNT_LO, 16'h0000);
      cpu_model_i.wr1(ADDR_CTRL_B, {5'h00, e ? CS_EXT_RISE : CS_EXT_FALL});
      repeat (5)
      begin
        repeat (4) @(posedge ref_clk);
        ext_pin <= 1'b1;
        repeat (4) @(posedge ref_clk);
        ext_pin <= 1'b0;
      end
      repeat (8) @(posedge ref_clk);
      cpu_model_i.wr1(ADDR_CTRL_B, 8'h00);
      cpu_model_i.rd16(ADDR_CNT_LO, v);
      chk(v, 16'h0005);
    end
    $display("test ext done");
  endtask

  // Guards every wait of the run at once
  initial
  begin
    repeat (100000) @(posedge ref_clk);
    errors++;
    results();
  end

  initial
  begin
    {ref_clk, sys_rst, ext_pin, cap_pin, cmp_out, cap_sel} = 6'h10;
    repeat (16) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    cpu_model_i.rd(ADDR_POWER, b);
    chk(b, {7'h00, RST_POWER});
    cpu_model_i.rd(4'hF, b);
    chk(b, 8'h00);
    chk(irq, 1'b0);
    $display("test reset done");
    cpu_model_i.power_up();
    t_access();
    t_irq();
    t_peak();
    t_pwm_a();
    t_capture();
    t_ext();
    results();
  end
endmodule
`default_nettype wire
